// ### isp_slave_port.sv
`include "isp_params.svh"
`default_nettype none

// Functional notes
// - slave receiver/transmitter only; never drives SCL, never arbitrates.
// - handles standard, fast and fast-plus rates; no high-speed mode.
// - never stretches SCL; every bit keeps pace with the master.
// - general call address is not answered; no bus software reset.
// - the device-identification read-out is not implemented.
// - spike filtering on both lines is on whenever this port is selected.
// - SDA changes only while SCL is low, except START and STOP.
// - SDA falling while SCL high is a START; bus becomes busy.
// - SDA rising while SCL high is a STOP; current transfer ends.
// - repeated START acts like START: bus stays busy, address follows.
// - bytes go MSB first, each followed by a master-clocked acknowledge.
// - transmitter releases SDA at acknowledge; receiver holds it low.
// - master NACKs last read byte; slave then releases SDA.
// - first byte after START compared with address, upper bits 01010.
// - low two address bits come from select pins or stored config.
// - write: address+W, register address byte, data to incrementing addresses.
// - write aimed at FIFO location puts all data there, pointer stays.
// - read: pointer set by write frame, then address+R returns registers.
// - read at FIFO location returns FIFO every byte, pointer stays.
// - no limit on bytes per transfer.
// - idle bus: both lines high, SDA released by this port.
// - register pointer is loaded with seven bits of the address byte.
module isp_slave_port (
   input  wire logic                  clock_i,
   input  wire logic                  reset_i,
   input  wire logic                  i2c_sel_i,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output var  logic                  sda_o,
   output var  logic                  sda_oe_o,
   input  wire logic [1:0]            adr_pin_i,
   input  wire logic [1:0]            adr_cfg_i,
   input  wire logic                  adr_from_cfg_i,
   output var  isp_pkg::isp_reg_req_t reg_req_o,
   input  wire logic [7:0]            reg_rdata_i,
   output var  logic                  bus_busy_o
);

   // filtered bus lines and their previous values
   logic [1:0]            raw_v;
   logic [1:0]            filt_v;
   isp_pkg::isp_line_t    line;
   isp_pkg::isp_line_t    line_q;
   isp_pkg::isp_line_t    next_line_q;

   // protocol state and bit counter
   isp_pkg::isp_state_t   state;
   isp_pkg::isp_state_t   next_state;
   logic [3:0]            cnt;
   logic [3:0]            next_cnt;

   // byte shifting in both directions
   logic [7:0]            shreg;
   logic [7:0]            next_shreg;
   logic [7:0]            txd;
   logic [7:0]            next_txd;

   // register pointer and frame flags
   logic [6:0]            ptr;
   logic [6:0]            next_ptr;
   logic                  rw;
   logic                  next_rw;
   logic                  first;
   logic                  next_first;
   logic                  mack;
   logic                  next_mack;
   logic                  fetch;
   logic                  next_fetch;

   // next values of the registered outputs
   isp_pkg::isp_reg_req_t next_req;
   logic                  next_oe;
   logic                  next_busy;

   // low address bits, synchronised from the pins
   logic [1:0]            adr_s1;
   logic [1:0]            adr_s2;
   logic [1:0]            next_adr_s1;
   logic [1:0]            next_adr_s2;
   logic [1:0]            adr_lo;

   // bus events on the filtered lines
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_det;
   logic                  stop_det;
   logic                  fifo_hit;

   // raw pins packed in the line struct's bit order: scl above sda
   assign raw_v = {scl_i, sda_i};
   assign line  = isp_pkg::isp_line_t'(filt_v);

   // one filter per bus line, active whenever this interface is selected;
   // each filter also holds the two synchroniser stages of its pin,
   // so no logic here ever reads a raw pin level
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         isp_spike_filter #(
            .LEN (`ISP_SPIKE_CYC)
         ) u_filt (
            .clock_i (clock_i),
            .reset_i (reset_i),
            .en_i    (i2c_sel_i),
            .raw_i   (raw_v[gi]),
            .filt_o  (filt_v[gi])
         );
      end
   endgenerate

   // bus events seen on the filtered lines
   assign scl_rise  = line.scl & ~line_q.scl;
   assign scl_fall  = ~line.scl & line_q.scl;
   assign start_det = line.scl & line_q.scl & line_q.sda & ~line.sda;
   assign stop_det  = line.scl & line_q.scl & ~line_q.sda & line.sda;
   assign fifo_hit  = (ptr == `ISP_FIFO_ADDR);

   // low address bits from synchronised pins or stored configuration
   assign adr_lo = adr_from_cfg_i ? adr_cfg_i : adr_s2;

   // protocol sequencing, pointer and register requests
   // every action keys on a filtered scl or sda edge, so the port answers
   // about ten cycles after the pin moves, well inside the low phase
   // even at the fastest rate; scl is never held, so nothing may wait
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_shreg = shreg;
      next_txd   = txd;
      next_ptr   = ptr;
      next_rw    = rw;
      next_first = first;
      next_mack  = mack;
      next_fetch = 1'b0;
      next_oe    = sda_oe_o;
      next_busy  = bus_busy_o;
      next_req   = '0;
      // read data arrive in the cycle after the request and wait in txd
      // until the first bit of their byte is due
      if (fetch) begin
         next_txd = reg_rdata_i;
      end
      if (!i2c_sel_i) begin
         next_state = isp_pkg::ISP_IDLE;
         next_oe    = 1'b0;
         next_busy  = 1'b0;
      end else if (start_det) begin
         // a start or repeated start wins over any byte in flight
         // pointer left untouched so a read resumes where the write left it
         next_state = isp_pkg::ISP_ADDR;
         next_cnt   = `ISP_CNT_ZERO;
         next_oe    = 1'b0;
         next_busy  = 1'b1;
         next_mack  = 1'b0;
      end else if (stop_det) begin
         next_state = isp_pkg::ISP_IDLE;
         next_oe    = 1'b0;
         next_busy  = 1'b0;
      end else begin
         case (state)
            isp_pkg::ISP_IDLE: begin
               next_oe = 1'b0;
            end
            // bytes toward the port: shift on rises, answer after the eighth fall
            isp_pkg::ISP_ADDR, isp_pkg::ISP_WR_BYTE: begin
               if (scl_rise && cnt != `ISP_BITS_RX) begin
                  next_shreg = {shreg[6:0], line.sda};
                  next_cnt   = cnt + `ISP_CNT_ONE;
               end else if (scl_fall && cnt == `ISP_BITS_RX) begin
                  next_cnt = `ISP_CNT_ZERO;
                  if (state == isp_pkg::ISP_ADDR) begin
                     // general call and reserved codes never match the fixed part
                     if (shreg[7:1] == {`ISP_ADDR_HI, adr_lo}) begin
                        next_oe    = 1'b1;
                        next_rw    = shreg[0];
                        next_state = isp_pkg::ISP_ADDR_ACK;
                        if (shreg[0]) begin
                           next_req.rd   = 1'b1;
                           next_req.addr = ptr;
                           next_fetch    = 1'b1;
                        end
                     end else begin
                        next_state = isp_pkg::ISP_IDLE;
                     end
                  end else begin
                     next_oe    = 1'b1;
                     next_state = isp_pkg::ISP_WR_ACK;
                     // register address byte loads the pointer, later bytes are written
                     if (first) begin
                        next_ptr = shreg[6:0];
                     end else begin
                        next_req.wr    = 1'b1;
                        next_req.addr  = ptr;
                        next_req.wdata = shreg;
                        if (!fifo_hit) begin
                           next_ptr = ptr + `ISP_PTR_STEP;
                        end
                     end
                  end
               end
            end

            // address acknowledged: turn round for a read or await the register byte
            isp_pkg::ISP_ADDR_ACK: begin
               if (scl_fall) begin
                  next_cnt = `ISP_CNT_ZERO;
                  // first read bit goes out on the acknowledge's falling edge
                  if (rw) begin
                     next_state = isp_pkg::ISP_RD_BYTE;
                     next_shreg = txd;
                     next_oe    = ~txd[7];
                  end else begin
                     next_state = isp_pkg::ISP_WR_BYTE;
                     next_first = 1'b1;
                     next_oe    = 1'b0;
                  end
               end
            end

            // register or data byte acknowledged: let go at the end of the pulse
            isp_pkg::ISP_WR_ACK: begin
               if (scl_fall) begin
                  next_oe    = 1'b0;
                  next_first = 1'b0;
                  next_state = isp_pkg::ISP_WR_BYTE;
               end
            end

            // bytes from the port: each scl fall puts the next bit out, the eighth lets go for the acknowledge
            isp_pkg::ISP_RD_BYTE: begin
               if (scl_fall) begin
                  if (cnt == `ISP_BITS_TX_LAST) begin
                     // transmitter lets go for the master's acknowledge
                     next_oe    = 1'b0;
                     next_cnt   = `ISP_CNT_ZERO;
                     next_state = isp_pkg::ISP_RD_ACK;
                     if (!fifo_hit) begin
                        next_ptr = ptr + `ISP_PTR_STEP;
                     end
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_oe    = ~shreg[6];
                     next_cnt   = cnt + `ISP_CNT_ONE;
                  end
               end
            end

            // master's answer to a read byte
            isp_pkg::ISP_RD_ACK: begin
               if (scl_rise) begin
                  // acknowledge: fetch the next byte ahead of its first bit
                  if (!line.sda) begin
                     next_mack     = 1'b1;
                     next_req.rd   = 1'b1;
                     next_req.addr = ptr;
                     next_fetch    = 1'b1;
                  end else begin
                     // not-acknowledge: stay released until start or stop
                     next_state = isp_pkg::ISP_IDLE;
                  end
               end else if (scl_fall && mack) begin
                  next_mack  = 1'b0;
                  next_state = isp_pkg::ISP_RD_BYTE;
                  next_shreg = txd;
                  next_oe    = ~txd[7];
               end
            end

            // unused codes fall back to idle with the line released
            default: begin
               next_state = isp_pkg::ISP_IDLE;
               next_oe    = 1'b0;
            end
         endcase
      end
   end

   // state registers; SDA is only ever pulled low, SCL never driven
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state      <= isp_pkg::ISP_IDLE;
         cnt        <= `ISP_CNT_ZERO;
         shreg      <= `ISP_BYTE_ZERO;
         txd        <= `ISP_BYTE_ZERO;
         ptr        <= `ISP_PTR_RESET;
         rw         <= 1'b0;
         first      <= 1'b0;
         mack       <= 1'b0;
         fetch      <= 1'b0;
         sda_oe_o   <= 1'b0;
         sda_o      <= 1'b0;
         bus_busy_o <= 1'b0;
         reg_req_o  <= '0;
      end else begin
         state      <= next_state;
         cnt        <= next_cnt;
         shreg      <= next_shreg;
         txd        <= next_txd;
         ptr        <= next_ptr;
         rw         <= next_rw;
         first      <= next_first;
         mack       <= next_mack;
         fetch      <= next_fetch;
         sda_oe_o   <= next_oe;
         sda_o      <= 1'b0;
         bus_busy_o <= next_busy;
         reg_req_o  <= next_req;
      end
   end

   // sampled copies for edge detection and the address pin synchroniser
   always_comb begin
      next_line_q = line;
      next_adr_s1 = adr_pin_i;
      next_adr_s2 = adr_s1;
   end

   // both lines start at their idle level, so no false edge follows reset;
   // only the second address stage is read by the logic
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         line_q <= '1;
         adr_s1 <= 2'h0;
         adr_s2 <= 2'h0;
      end else begin
         line_q <= next_line_q;
         adr_s1 <= next_adr_s1;
         adr_s2 <= next_adr_s2;
      end
   end

endmodule

`default_nettype wire

// ### isp_params.svh
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

// fixed upper part of the 7-bit device address
`define ISP_ADDR_HI        5'h0a
// register location that streams and is never advanced past
`define ISP_FIFO_ADDR      7'h05
// system clock period and spike width to suppress, in ns
`define ISP_CLK_NS         8
`define ISP_SPIKE_NS       50
// least spike-suppression time rounded up to whole cycles
`define ISP_SPIKE_CYC      ((`ISP_SPIKE_NS + `ISP_CLK_NS - 1) / `ISP_CLK_NS)
// bit counts within a byte
`define ISP_BITS_RX        4'h8
`define ISP_BITS_TX_LAST   4'h7
`define ISP_CNT_ZERO       4'h0
`define ISP_CNT_ONE        4'h1
`define ISP_PTR_STEP       7'h01
`define ISP_PTR_RESET      7'h00
`define ISP_BYTE_ZERO      8'h00

`endif

// ### isp_pkg.sv
`default_nettype none

package isp_pkg;

   // protocol states of the slave port
   typedef enum logic [2:0] {
      ISP_IDLE,
      ISP_ADDR,
      ISP_ADDR_ACK,
      ISP_WR_BYTE,
      ISP_WR_ACK,
      ISP_RD_BYTE,
      ISP_RD_ACK
   } isp_state_t;

   // one register access toward the register file
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } isp_reg_req_t;

   // the two bus lines after filtering
   typedef struct packed {
      logic scl;
      logic sda;
   } isp_line_t;

endpackage

`default_nettype wire

// ### isp_spike_filter.sv
`include "isp_params.svh"
`default_nettype none

module isp_spike_filter #(
   parameter int LEN = `ISP_SPIKE_CYC
) (
   input  wire logic clock_i,
   input  wire logic reset_i,
   input  wire logic en_i,
   input  wire logic raw_i,
   output var  logic filt_o
);

   logic       sync_a;
   logic       sync_b;
   logic [7:0] run;
   logic [7:0] next_run;
   logic       next_filt;

   // while enabled, a new level is taken only after it has stood for LEN cycles; disabled, sync_b passes straight through
   always_comb begin
      next_run  = 8'h00;
      next_filt = filt_o;
      if (!en_i) begin
         next_filt = sync_b;
      end else if (sync_b != filt_o) begin
         if (run == 8'(LEN - 1)) begin
            next_filt = sync_b;
         end else begin
            next_run = run + 8'h01;
         end
      end
   end

   // two-stage synchroniser, then the filter state
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         run    <= 8'h00;
         filt_o <= 1'b1;
      end else begin
         sync_a <= raw_i;
         sync_b <= sync_a;
         run    <= next_run;
         filt_o <= next_filt;
      end
   end

endmodule

`default_nettype wire

// ### isp_slave_port_chk.sv
`default_nettype none
module isp_slave_port_chk (
   input wire logic                  clock_i,
   input wire logic                  reset_i,
   input wire logic                  i2c_sel_i,
   input wire logic                  scl_i,
   input wire logic                  sda_o,
   input wire logic                  sda_oe_o,
   input wire isp_pkg::isp_reg_req_t reg_req_o,
   input wire logic                  bus_busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // register requests are single-cycle pulses
   sequence wr_pulse;
      reg_req_o.wr ##1 !reg_req_o.wr;
   endsequence
   sequence rd_pulse;
      reg_req_o.rd ##1 !reg_req_o.rd;
   endsequence
   open_drain_a: assert property (sda_o == 1'b0)
      else $error("sda value not low");
   idle_release_a: assert property (!bus_busy_o |-> !sda_oe_o)
      else $error("sda pulled while bus free");
   wr_single_a: assert property (reg_req_o.wr |-> wr_pulse)
      else $error("write pulse too long");
   rd_single_a: assert property (reg_req_o.rd |-> rd_pulse)
      else $error("read pulse too long");
   wr_ack_a: assert property (reg_req_o.wr |-> sda_oe_o && bus_busy_o)
      else $error("write without acknowledge");
   req_quiet_a: assert property (!(reg_req_o.wr || reg_req_o.rd) |->
      reg_req_o.addr == 7'h00 && reg_req_o.wdata == 8'h00)
      else $error("request fields not cleared");
   req_excl_a: assert property (!(reg_req_o.wr && reg_req_o.rd))
      else $error("read and write together");
   scl_low_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("sda moved while scl high");
   desel_idle_a: assert property (!i2c_sel_i [*4] |-> !bus_busy_o && !sda_oe_o)
      else $error("port active while deselected");
endmodule
`default_nettype wire

// ### isp_host_model.sv
`default_nettype none
module isp_host_model (
   input  wire logic clock_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int H = 63; // half bit, near 1 Mbit/s
   // both lines released outside frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic wait_c(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // start or repeated start, only ever made here
   task automatic start();
      wait_c(20);
      sda_o <= 1'b1;
      wait_c(H);
      scl_o <= 1'b1;
      wait_c(H);
      sda_o <= 1'b0;
      wait_c(H);
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      wait_c(20);
      sda_o <= 1'b0;
      wait_c(H);
      scl_o <= 1'b1;
      wait_c(H);
      sda_o <= 1'b1;
      wait_c(H);
   endtask
   // data moves while scl low, sampled mid high phase
   task automatic bit_x(input logic b, output logic r);
      wait_c(20);
      sda_o <= b;
      wait_c(H - 20);
      scl_o <= 1'b1;
      wait_c(H / 2);
      r = sda_i;
      wait_c(H - H / 2);
      scl_o <= 1'b0;
   endtask
   // msb first, then acknowledge clocked here; 1 releases sda
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
                       output logic a);
      for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
      bit_x(ack, a);
   endtask
endmodule
`default_nettype wire

// ### isp_slave_port_tb_top.sv
`include "isp_params.svh"
`default_nettype none
module isp_slave_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] DEV  = {`ISP_ADDR_HI, 2'b01};
   localparam logic [6:0] CFG  = {`ISP_ADDR_HI, 2'b10};
   localparam logic [6:0] FIFO = `ISP_FIFO_ADDR;
   logic                  clock_i, reset_i, sel, from_cfg, m_scl, m_sda, sda_o, sda_oe, busy;
   logic [1:0]            adr_pin, adr_cfg;
   isp_pkg::isp_reg_req_t req;
   wire logic             sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
   logic [7:0]            regs [128];
   wire logic [7:0]       rdata = regs[req.addr]; // stands while the read pulse does
   logic [15:0]           wexp [$], raddr [$];
   logic [6:0]            ptr;
   int                    err_total, samples_checked, seed;

   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   isp_slave_port i_isp_slave_port (.clock_i(clock_i), .reset_i(reset_i), .i2c_sel_i(sel),
      .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .adr_pin_i(adr_pin),
      .adr_cfg_i(adr_cfg), .adr_from_cfg_i(from_cfg), .reg_req_o(req), .reg_rdata_i(rdata),
      .bus_busy_o(busy));
   isp_host_model i_isp_host_model (.clock_i(clock_i), .sda_i(sda_w), .scl_o(m_scl),
      .sda_o(m_sda));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (err_total == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // register file: logs writes and read addresses against the model
   always @(posedge clock_i) begin
      if (req.wr) check({1'b0, req.addr, req.wdata}, wexp.size() ? wexp.pop_front() : 16'hffff);
      if (req.rd) begin
         check({9'h0, req.addr}, raddr.size() ? raddr.pop_front() : 16'hffff);
      end
   end

   // write frame; ok says whether the port should answer, rs skips the stop
   task automatic wr_frame(input logic [6:0] dev, input logic [7:0] ra, input int n,
                           input logic ok, input logic rs);
      logic [7:0] r, d;
      logic       a;
      i_isp_host_model.start();
      check(16'(busy), 16'(sel));
      i_isp_host_model.xfer({dev, 1'b0}, 1'b1, r, a);
      check(16'(a), 16'(!ok));
      i_isp_host_model.xfer(ra, 1'b1, r, a);
      check(16'(a), 16'(!ok));
      if (ok) ptr = ra[6:0];
      for (int k = 0; k < n; k++) begin
         d = 8'($random(seed));
         if (ok) begin
            wexp.push_back({1'b0, ptr, d});
            regs[ptr] = d;
         end
         i_isp_host_model.xfer(d, 1'b1, r, a);
         check(16'(a), 16'(!ok));
         if (ok && ptr != FIFO) ptr = ptr + 7'h01;
      end
      if (!rs) begin
         i_isp_host_model.stop();
         check(16'(busy), 16'h0);
      end
      check(16'(wexp.size()), 16'h0);
   endtask

   // read frame of n bytes, last one left unacknowledged
   task automatic rd_frame(input logic [6:0] dev, input int n);
      logic [7:0] r;
      logic [6:0] p;
      logic       a;
      p = ptr;
      for (int k = 0; k < n; k++) begin
         raddr.push_back({9'h0, p});
         if (p != FIFO) p = p + 7'h01;
      end
      i_isp_host_model.start();
      i_isp_host_model.xfer({dev, 1'b1}, 1'b1, r, a);
      check(16'(a), 16'h0);
      for (int k = 0; k < n; k++) begin
         i_isp_host_model.xfer(8'hff, 1'(k == n - 1), r, a);
         check(16'(r), 16'(regs[ptr]));
         if (ptr != FIFO) ptr = ptr + 7'h01;
      end
      i_isp_host_model.stop();
      check(16'(busy), 16'h0);
      check(16'(raddr.size()), 16'h0);
   endtask

   initial begin
      seed = 32'h5da8;
      reset_i = 1'b1;
      sel = 1'b1;
      from_cfg = 1'b0;
      adr_pin = 2'b01;
      adr_cfg = 2'b10;
      ptr = 7'h00;
      for (int k = 0; k < 128; k++) regs[k] = 8'($random(seed));
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (12) @(posedge clock_i);
      wr_frame(DEV, 8'h10, 4, 1'b1, 1'b0);
      rd_frame(DEV, 2);
      wr_frame(DEV, 8'h93, 0, 1'b1, 1'b1);
      rd_frame(DEV, 4);
      wr_frame(DEV, {1'b0, FIFO}, 3, 1'b1, 1'b0);
      wr_frame(DEV, {1'b0, FIFO}, 0, 1'b1, 1'b1);
      rd_frame(DEV, 3);
      wr_frame(DEV, 8'h7e, 3, 1'b1, 1'b0);
      wr_frame(CFG, 8'h20, 1, 1'b0, 1'b0);
      wr_frame(7'h00, 8'h20, 1, 1'b0, 1'b0);
      from_cfg <= 1'b1;
      wr_frame(CFG, 8'h20, 2, 1'b1, 1'b0);
      wr_frame(DEV, 8'h20, 1, 1'b0, 1'b0);
      sel <= 1'b0;
      wr_frame(CFG, 8'h20, 1, 1'b0, 1'b0);
      sel <= 1'b1;
      reset_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (12) @(posedge clock_i);
      ptr = 7'h00;
      rd_frame(CFG, 2);
      results();
   end

   // cuts a hang short
   initial begin
      repeat (100000) @(posedge clock_i);
      err_total++;
      results();
   end
endmodule

bind isp_slave_port isp_slave_port_chk i_isp_slave_port_chk (.clock_i(clock_i),
   .reset_i(reset_i), .i2c_sel_i(i2c_sel_i), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .reg_req_o(reg_req_o), .bus_busy_o(bus_busy_o));
`default_nettype wire
